// >>> verilog/cfl_config_loader.sv
`timescale 1ns/1ps
module cfl_config_loader
   import cfl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] bus_mode_select,
   input  wire logic [1:0] swing_select_pin,
   input  wire logic [1:0] deemph_pin,
   input  wire logic [3:0] addr_strap,
   input  wire logic       load_request_n,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            scl_oe,
   output logic            sda_o,
   output logic            sda_oe,
   output logic            load_done_n,
   output logic [2:0]      swing_a,
   output logic [2:0]      swing_b,
   output logic [2:0]      deemph,
   output logic            kr_pass
);
   cfl_state_t s_q, s_d;
   cfl_pins_t  pin_in;
   logic       start, stop, rise, fall, bus_idle, pin_mode, smb_mode, slv_en, tick, end_bit;
   logic       wr_ev, wr_ok;
   logic [3:0] idx;
   logic [6:0] own_addr;
   logic [7:0] rd_byte;
   logic [5:0] chunk;
   logic [1:0] pg;

   // ----------------------------------------------------------------
   // pin sampling and bus conditions
   // ----------------------------------------------------------------
   assign pin_in   = {bus_mode_select, swing_select_pin, deemph_pin, addr_strap, load_request_n, scl_i, sda_i};
   assign start    = s_q.p2.scl & s_q.pv_scl & s_q.pv_sda & ~s_q.p2.sda;
   assign stop     = s_q.p2.scl & s_q.pv_scl & ~s_q.pv_sda & s_q.p2.sda;
   assign rise     = s_q.p2.scl & ~s_q.pv_scl;
   assign fall     = ~s_q.p2.scl & s_q.pv_scl;
   assign bus_idle = (s_q.stop_seen && s_q.hi_cnt > BUF_CYC) || s_q.hi_cnt > HIGH_CYC;
   assign pin_mode = s_q.p2.mode != LV_1 && s_q.p2.mode != LV_F;
   assign smb_mode = !pin_mode;
   // straps rely on the pad pull-downs, so an open strap already arrives as 0
   assign idx      = (smb_mode && s_q.p2.sel == LV_1) ? 4'h0 : s_q.p2.strap;
   assign own_addr = SLV_BASE + {3'h0, idx};
   assign slv_en   = s_q.p2.mode == LV_1 || s_q.ls == L_DONE;
   assign rd_byte  = (s_q.ptr[7:6] == 2'h0) ? s_q.regs[s_q.ptr[5:0]] : 8'h00;
   assign wr_ev    = s_q.sl == SL_RX && fall && s_q.sbit == 4'h8 && s_q.sbyte == 2'h2;
   assign wr_ok    = s_q.ptr[7:6] == 2'h0 && (s_q.ptr[5:0] == REG_CTRL || s_q.regs[REG_CTRL][CTRL_EN_BIT]);
   assign tick     = s_q.qc == QTR_CYC - 4'h1;
   assign end_bit  = tick && s_q.q == 2'h3;
   assign chunk    = (s_q.burst == 8'h00 || {2'h0, s_q.rem} <= s_q.burst) ? s_q.rem : s_q.burst[5:0];
   assign pg       = s_q.hdr0[HDR_BIG_BIT] ? s_q.addr[9:8] : 2'h0;

   always_comb
   begin
      s_d = s_q;
      s_d.p1 = pin_in;
      s_d.p2 = s_q.p1;
      s_d.pv_scl = s_q.p2.scl;
      s_d.pv_sda = s_q.p2.sda;
      if (s_q.p2.scl && s_q.p2.sda)
      begin
         if (s_q.hi_cnt <= HIGH_CYC) s_d.hi_cnt = s_q.hi_cnt + 10'h001;
      end
      else s_d.hi_cnt = 10'h000;
      if (start) s_d.stop_seen = 1'b0;
      else if (stop) s_d.stop_seen = 1'b1;

      // ----------------------------------------------------------------
      // slave side
      // ----------------------------------------------------------------
      unique case (s_q.sl)
         SL_IDLE: ;
         SL_RX:
         begin
            if (rise)
            begin
               s_d.ssh = {s_q.ssh[6:0], s_q.p2.sda};
               s_d.sbit = s_q.sbit + 4'h1;
            end
            else if (fall && s_q.sbit == 4'h8)
            begin
               if (s_q.sbyte == 2'h0)
               begin
                  if (s_q.ssh[7:1] == own_addr)
                  begin
                     s_d.sdrv = 1'b1;
                     s_d.rw = s_q.ssh[0];
                     s_d.sl = SL_ACK;
                  end
                  else s_d.sl = SL_IDLE;
               end
               else
               begin
                  s_d.sdrv = 1'b1;
                  s_d.sl = SL_ACK;
                  if (s_q.sbyte == 2'h1) s_d.ptr = s_q.ssh;
                  else
                  begin
                     if (wr_ok) s_d.regs[s_q.ptr[5:0]] = s_q.ssh;
                     s_d.ptr = s_q.ptr + 8'h01;
                  end
               end
            end
         end
         SL_ACK:
         begin
            if (fall)
            begin
               s_d.sdrv = 1'b0;
               s_d.sbit = 4'h0;
               if (s_q.rw)
               begin
                  s_d.ssh = rd_byte;
                  s_d.sdrv = ~rd_byte[7];
                  s_d.sl = SL_TX;
               end
               else
               begin
                  s_d.sl = SL_RX;
                  if (s_q.sbyte != 2'h2) s_d.sbyte = s_q.sbyte + 2'h1;
               end
            end
         end
         SL_TX:
         begin
            if (rise) s_d.sbit = s_q.sbit + 4'h1;
            else if (fall && s_q.sbit == 4'h8)
            begin
               s_d.sdrv = 1'b0;
               s_d.sl = SL_RACK;
            end
            else if (fall)
            begin
               s_d.ssh = {s_q.ssh[6:0], 1'b0};
               s_d.sdrv = ~s_q.ssh[6];
            end
         end
         SL_RACK:
         begin
            if (rise && s_q.p2.sda) s_d.sl = SL_IDLE;
            else if (rise)
            begin
               s_d.ptr = s_q.ptr + 8'h01;
               s_d.sl = SL_ACK;
            end
         end
      endcase
      if (!slv_en || stop)
      begin
         s_d.sl = SL_IDLE;
         s_d.sdrv = 1'b0;
      end
      else if (start)
      begin
         s_d.sl = SL_RX;
         s_d.sbit = 4'h0;
         s_d.sbyte = 2'h0;
         s_d.sdrv = 1'b0;
      end
      else if (bus_idle)
      begin
         s_d.sl = SL_IDLE;
         s_d.sdrv = 1'b0;
      end

      // ----------------------------------------------------------------
      // memory loader; in the byte and stop states scl pulled low in q0/q1, released in q2/q3
      // ----------------------------------------------------------------
      if (s_q.ls inside {L_S1, L_CW, L_AD, L_S2, L_CR, L_RD, L_SP})
      begin
         s_d.qc = tick ? 4'h0 : s_q.qc + 4'h1;
         if (tick) s_d.q = s_q.q + 2'h1;
      end
      unique case (s_q.ls)
         L_WAIT:
         begin
            s_d.mscl = 1'b0;
            s_d.msda = 1'b0;
            if (s_q.p2.mode == LV_F && !s_q.p2.req_n && bus_idle)
            begin
               s_d.ls = L_S1;
               s_d.ph = P_HDR;
               s_d.addr = 10'h000;
               s_d.rem = HDR_LEN;
               s_d.bcnt = 6'h00;
               s_d.crc = 8'h00;
               s_d.qc = 4'h0;
               s_d.q = 2'h0;
            end
         end
         L_S1, L_S2:
         begin
            // sda falls in q2 with scl high: a start, never a stop
            s_d.mscl = s_q.q == 2'h0 || s_q.q == 2'h3;
            s_d.msda = s_q.q[1];
            if (end_bit)
            begin
               s_d.ls = (s_q.ls == L_S1) ? L_CW : L_CR;
               s_d.msh = {EE_ADDR | {5'h00, pg}, s_q.ls == L_S2};
               s_d.bi = 4'h0;
               if (s_q.ls == L_S1) s_d.kl = chunk;
            end
         end
         L_CW, L_AD, L_CR:
         begin
            s_d.mscl = ~s_q.q[1];
            if (s_q.q != 2'h0) s_d.msda = s_q.bi != 4'h8 && !s_q.msh[7];
            if (end_bit && s_q.bi != 4'h8)
            begin
               s_d.bi = s_q.bi + 4'h1;
               s_d.msh = {s_q.msh[6:0], 1'b0};
            end
            else if (end_bit && s_q.p2.sda) s_d.ls = L_FAIL;
            else if (end_bit)
            begin
               s_d.bi = 4'h0;
               s_d.msh = s_q.addr[7:0];
               s_d.ls = (s_q.ls == L_CW) ? L_AD : (s_q.ls == L_AD) ? L_S2 : L_RD;
            end
         end
         L_RD:
         begin
            s_d.mscl = ~s_q.q[1];
            if (s_q.q != 2'h0) s_d.msda = s_q.bi == 4'h8 && s_q.kl != 6'h01;
            if (end_bit && s_q.bi != 4'h8)
            begin
               s_d.bi = s_q.bi + 4'h1;
               s_d.msh = {s_q.msh[6:0], s_q.p2.sda};
            end
            else if (end_bit)
            begin
               s_d.bi = 4'h0;
               s_d.addr = s_q.addr + 10'h001;
               s_d.rem = s_q.rem - 6'h01;
               s_d.kl = s_q.kl - 6'h01;
               s_d.bcnt = s_q.bcnt + 6'h01;
               if (s_q.kl == 6'h01) s_d.ls = L_SP;
               unique case (s_q.ph)
                  P_HDR:
                  begin
                     s_d.crc = crc8(s_q.crc, s_q.msh);
                     if (s_q.bcnt == 6'h00) s_d.hdr0 = s_q.msh;
                     if (s_q.bcnt == HDR_BURST) s_d.burst = s_q.msh;
                  end
                  P_MAP:
                  begin
                     if (s_q.bcnt == 6'h00) s_d.mhi = s_q.msh[1:0];
                     else s_d.addr = {s_q.mhi, s_q.msh};
                  end
                  P_DAT:
                  begin
                     if (s_q.bcnt < DEV_LEN) s_d.crc = crc8(s_q.crc, s_q.msh);
                     if (s_q.bcnt == VOD_IDX) s_d.vod = s_q.msh[VOD_LSB +: 3];
                     if (s_q.bcnt == DEV_LEN) s_d.crc_ok = s_q.msh == s_q.crc;
                  end
                  default: ;
               endcase
            end
         end
         L_SP:
         begin
            // sda held in q0 so it never moves on the same edge as scl
            s_d.mscl = ~s_q.q[1];
            if (s_q.q != 2'h0) s_d.msda = s_q.q != 2'h3;
            if (end_bit && s_q.rem != 6'h00) s_d.ls = L_S1;
            else if (end_bit)
            begin
               s_d.bcnt = 6'h00;
               s_d.ls = L_S1;
               s_d.ph = P_DAT;
               s_d.rem = BLK_LEN;
               if (s_q.ph == P_HDR && s_q.hdr0[HDR_MAP_BIT])
               begin
                  s_d.ph = P_MAP;
                  s_d.rem = 6'h02;
                  s_d.addr = 10'(HDR_LEN) + {5'h00, idx, 1'b0};
               end
               else if (s_q.ph == P_HDR) s_d.addr = 10'(HDR_LEN) + 10'(idx) * 10'(BLK_LEN);
               else if (s_q.ph == P_DAT && (!s_q.hdr0[HDR_CRC_BIT] || s_q.crc_ok))
               begin
                  s_d.ls = L_DONE;
                  s_d.regs[REG_SWA][SW_LSB +: 3] = s_q.vod;
               end
               else if (s_q.ph == P_DAT) s_d.ls = L_FAIL;
            end
         end
         L_DONE:
         begin
            s_d.mscl = 1'b0;
            s_d.msda = 1'b0;
            s_d.done_n = 1'b0;
         end
         L_FAIL: s_d.mscl = 1'b1;
      endcase
      s_d.sda_oe = s_d.msda | s_d.sdrv;

      // ----------------------------------------------------------------
      // analog setting outputs
      // ----------------------------------------------------------------
      s_d.kr = pin_mode && s_q.p2.sel == LV_1;
      if (pin_mode)
      begin
         s_d.swing_a = SWING_700;
         s_d.swing_b = pin_vod(s_q.p2.sel, s_q.p2.dem);
         s_d.deemph = pin_dem(s_q.p2.sel, s_q.p2.dem);
      end
      else
      begin
         s_d.swing_a = s_q.regs[REG_SWA][SW_LSB +: 3];
         s_d.swing_b = s_q.regs[REG_SWB][SW_LSB +: 3];
         s_d.deemph = s_q.regs[REG_DEMB][2:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.regs <= {64{REG_RST}};
         s_q.done_n <= 1'b1;
         // idle bus is high; starting the samplers there avoids a false edge
         s_q.p1.scl <= 1'b1;
         s_q.p1.sda <= 1'b1;
         s_q.p2.scl <= 1'b1;
         s_q.p2.sda <= 1'b1;
         s_q.pv_scl <= 1'b1;
         s_q.pv_sda <= 1'b1;
      end
      else s_q <= s_d;
   end

   assign scl_o       = s_q.zero;
   assign sda_o       = s_q.zero;
   assign scl_oe      = s_q.mscl;
   assign sda_oe      = s_q.sda_oe;
   assign load_done_n = s_q.done_n;
   assign swing_a     = s_q.swing_a;
   assign swing_b     = s_q.swing_b;
   assign deemph      = s_q.deemph;
   assign kr_pass     = s_q.kr;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence pin_held;
      pin_mode [*2];
   endsequence
   sequence ack_out;
      s_q.sdrv ##1 s_q.sda_oe;
   endsequence
   chk_swing_pin: assert property (pin_held |=> s_q.swing_a == SWING_700) else $error("swing a not 700");
   chk_swing_reg: assert property (smb_mode |=> s_q.swing_a == $past(s_q.regs[REG_SWA][4:2])) else $error("swing a");
   chk_strap_zero: assert property (smb_mode && s_q.p2.sel == LV_1 |-> own_addr == SLV_BASE) else $error("strap");
   chk_pin_table: assert property (pin_mode && s_q.p2.sel == LV_1 && s_q.p2.dem == LV_R
                                   |=> s_q.deemph == 3'h1 && s_q.swing_b == 3'h6) else $error("pin table");
   chk_kr_mode: assert property (1'b1 |=> s_q.kr == $past(pin_mode && s_q.p2.sel == LV_1)) else $error("kr");
   chk_slave_gate: assert property (s_q.sl != SL_IDLE |-> $past(slv_en)) else $error("slave not enabled");
   chk_addr_ack: assert property (s_q.sl == SL_RX && fall && s_q.sbit == 4'h8 && s_q.sbyte == 2'h0
                                  && s_q.ssh[7:1] == own_addr && !stop && !start |=> ack_out) else $error("no ack");
   chk_write_gate: assert property (wr_ev && !start && !stop && !wr_ok |=> s_q.regs == $past(s_q.regs)) else $error("gate");
   chk_wait_quiet: assert property (s_q.ls == L_WAIT && s_q.p2.req_n |=> !s_q.mscl && !s_q.msda && s_q.done_n)
      else $error("bus touched while waiting");
   chk_done_low: assert property (s_q.ls == L_DONE |=> !s_q.done_n && !s_q.mscl) else $error("done");
   chk_fail_hold: assert property (s_q.ls == L_FAIL |=> s_q.ls == L_FAIL && s_q.mscl) else $error("fail released");
   chk_crc_fail: assert property (s_q.ls == L_SP && end_bit && s_q.ph == P_DAT && s_q.rem == 6'h00
                                  && s_q.hdr0[HDR_CRC_BIT] && !s_q.crc_ok |=> s_q.ls == L_FAIL) else $error("crc");
endmodule : cfl_config_loader

// >>> verilog/cfl_pkg.sv
package cfl_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         CLK_MHZ   = 20;
   localparam int         T_QTR_NS  = 250;
   localparam int         T_BUF_NS  = 4700;
   localparam int         T_HIGH_NS = 50000;
   localparam logic [3:0] QTR_CYC   = 4'((T_QTR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] BUF_CYC   = 10'((T_BUF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] HIGH_CYC  = 10'(T_HIGH_NS * CLK_MHZ / 1000);
   // ----------------------------------------------------------------
   // addresses, registers, image layout
   // ----------------------------------------------------------------
   localparam logic [6:0] SLV_BASE    = 7'h58;
   localparam logic [6:0] EE_ADDR     = 7'h50;
   localparam logic [7:0] CRC_POLY    = 8'h07;
   localparam logic [7:0] REG_RST     = 8'h00;
   localparam logic [5:0] REG_CTRL    = 6'h06;
   localparam int         CTRL_EN_BIT = 3;
   localparam logic [5:0] REG_SWA     = 6'h23;
   localparam logic [5:0] REG_SWB     = 6'h2d;
   localparam logic [5:0] REG_DEMB    = 6'h11;
   localparam int         SW_LSB      = 2;
   localparam int         HDR_CRC_BIT = 7;
   localparam int         HDR_MAP_BIT = 6;
   localparam int         HDR_BIG_BIT = 5;
   localparam logic [5:0] HDR_LEN     = 6'h03;
   localparam logic [5:0] HDR_BURST   = 6'h02;
   localparam logic [5:0] DEV_LEN     = 6'h25;
   localparam logic [5:0] BLK_LEN     = 6'h26;
   localparam logic [5:0] VOD_IDX     = 6'h0f;
   localparam int         VOD_LSB     = 4;
   localparam logic [2:0] SWING_700   = 3'h0;

   typedef enum logic [1:0] {LV_0, LV_R, LV_F, LV_1} cfl_lvl_t;
   typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_RACK} cfl_sl_t;
   typedef enum logic [3:0] {L_WAIT, L_S1, L_CW, L_AD, L_S2, L_CR, L_RD, L_SP, L_DONE, L_FAIL} cfl_ld_t;
   typedef enum logic [1:0] {P_HDR, P_MAP, P_DAT} cfl_ph_t;

   typedef struct packed {
      cfl_lvl_t   mode;
      cfl_lvl_t   sel;
      cfl_lvl_t   dem;
      logic [3:0] strap;
      logic       req_n;
      logic       scl;
      logic       sda;
   } cfl_pins_t;

   typedef struct packed {
      logic [63:0][7:0] regs;
      cfl_pins_t        p1, p2;
      logic             pv_scl, pv_sda, stop_seen;
      logic [9:0]       hi_cnt;
      cfl_sl_t          sl;
      logic [3:0]       sbit;
      logic [1:0]       sbyte;
      logic             rw, sdrv;
      logic [7:0]       ssh, ptr;
      cfl_ld_t          ls;
      cfl_ph_t          ph;
      logic [3:0]       qc, bi;
      logic [1:0]       q, mhi;
      logic [7:0]       msh, hdr0, burst, crc;
      logic [9:0]       addr;
      logic [5:0]       rem, kl, bcnt;
      logic [2:0]       vod, swing_a, swing_b, deemph;
      logic             crc_ok, mscl, msda, sda_oe, done_n, zero, kr;
   } cfl_state_t;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
      return r;
   endfunction : crc8

   function automatic logic [2:0] pin_dem(input cfl_lvl_t s, input cfl_lvl_t m);
      return (s == LV_1) ? ((m == LV_0) ? 3'h0 : (m == LV_1) ? 3'h2 : 3'h1)
                         : ((m == LV_0) ? 3'h0 : (m == LV_F) ? 3'h2 : (m == LV_R) ? 3'h3 : 3'h5);
   endfunction : pin_dem

   function automatic logic [2:0] pin_vod(input cfl_lvl_t s, input cfl_lvl_t m);
      return (s == LV_0) ? 3'h0 : (s == LV_F) ? 3'h3 : (s == LV_R) ? 3'h5
           : ((m == LV_0 || m == LV_F) ? 3'h4 : 3'h6);
   endfunction : pin_vod
endpackage : cfl_pkg

// >>> tb/cfl_eeprom_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// serial memory answering the loader's reads
// ------------------------------------------------
module cfl_eeprom_model
   import cfl_pkg::*;
(
   input  wire logic scl,
   input  wire logic sda,
   output logic      pull
);
   logic [7:0] mem [1024];
   logic [7:0] sh;
   logic [9:0] ptr;
   logic       go, rd, tx;
   int         n, ph, cnt, maxb;
   initial
   begin
      pull = 1'b0;
      go   = 1'b0;
      maxb = 0;
   end
   // first fall after a start is not a bit, hence n starts below zero
   always @(negedge sda)
   begin
      if (scl === 1'b1)
      begin
         n = -1;
         {ph, cnt, rd, tx, go} = 67'h1;
      end
   end
   always @(posedge sda) if (scl === 1'b1) go = 1'b0;
   always @(posedge scl)
   begin
      if (go && !tx && n < 8) sh = {sh[6:0], sda};
      if (go && tx && n == 8)
      begin
         cnt++;
         maxb = (cnt > maxb) ? cnt : maxb;
         go = ~sda;
      end
   end
   always @(negedge scl)
   begin
      if (go) n++;
      if (go && n == 8 && !tx)
      begin
         if (ph == 0) rd = sh[0];
         if (ph == 0 && !sh[0]) ptr[9:8] = sh[2:1];
         if (ph != 0) ptr[7:0] = sh;
         if (ph == 0) go = (sh[7:3] == EE_ADDR[6:2]);
         ph++;
         pull = go;
      end
      else if (go && n == 9)
      begin
         n = 0;
         pull = 1'b0;
         ptr = ptr + 10'(tx);
         tx = rd;
      end
      if (go && tx) pull = (n < 8) ? ~mem[ptr][7 - n] : 1'b0;
   end
endmodule : cfl_eeprom_model

// >>> tb/cfl_config_loader_test.sv
`timescale 1ns/1ps
module cfl_config_loader_test
   import cfl_pkg::*;
;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            req_n = 1'b1;
   logic            hscl = 1'b0;
   logic            hsda = 1'b0;
   logic [1:0]      mode = 2'h0;
   logic [1:0]      sel = 2'h0;
   logic [1:0]      dem = 2'h0;
   logic [3:0]      strap = 4'h0;
   logic [31:0]     seed = 32'h30;
   logic [7:0]      q, d;
   logic            a;
   int              s, bad_count = 0, checks_done = 0;
   wire logic       scl_oe, sda_oe, pull, done_n, kr, scl_drv, sda_drv;
   wire logic [2:0] sw_a, sw_b, de;
   // open-drain: any party pulling low wins, else the pull-up
   wire logic       scl = ~hscl & (~scl_oe | scl_drv);
   wire logic       sda = ~hsda & ~pull & (~sda_oe | sda_drv);
   localparam logic [5:0] KR_TAB [4] = '{6'h20, 6'h31, 6'h21, 6'h32};
   localparam logic [2:0] SW_TAB [4] = '{3'h0, 3'h5, 3'h3, 3'h0};
   localparam logic [2:0] DE_TAB [4] = '{3'h0, 3'h3, 3'h2, 3'h5};
   cfl_config_loader uut (.clk(clk), .rst(rst), .bus_mode_select(mode), .swing_select_pin(sel),
      .deemph_pin(dem), .addr_strap(strap), .load_request_n(req_n), .scl_i(scl), .sda_i(sda),
      .scl_o(scl_drv), .scl_oe(scl_oe), .sda_o(sda_drv), .sda_oe(sda_oe), .load_done_n(done_n), .swing_a(sw_a),
      .swing_b(sw_b), .deemph(de), .kr_pass(kr));
   cfl_eeprom_model ee (.scl(scl), .sda(sda), .pull(pull));
   always #25 clk = ~clk;
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] crc_of(input int st);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 40; i++)
      begin
         c ^= ee.mem[(i < 3) ? i : st + i - 3];
         for (int k = 0; k < 8; k++) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc_of
   task automatic final_report();
      if (bad_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   // slow bit: the pins pass a synchroniser, so 1 us per phase
   task automatic bt(input logic b, output logic r);
      hscl <= 1'b1;
      cyc(10);
      hsda <= ~b;
      cyc(10);
      hscl <= 1'b0;
      cyc(20);
      r = sda;
   endtask : bt
   // start is cond(1,0), stop is cond(0,1)
   task automatic cond(input logic b0, input logic b1);
      logic r;
      bt(b0, r);
      hsda <= ~b1;
      cyc(20);
   endtask : cond
   task automatic xb(input logic [7:0] o, input logic m, output logic [7:0] i, output logic ak);
      for (int k = 7; k >= 0; k--) bt(o[k], i[k]);
      bt(m, ak);
   endtask : xb
   task automatic wr(input logic [6:0] ad, input logic [5:0] rg, input logic [7:0] v);
      cond(1, 0);
      xb({ad, 1'b0}, 1'b1, q, a);
      cmp("addr ack", 0, a);
      xb({2'h0, rg}, 1'b1, q, a);
      cmp("reg ack", 0, a);
      xb(v, 1'b1, q, a);
      cmp("data ack", 0, a);
      cond(0, 1);
   endtask : wr
   task automatic rdr(input logic [6:0] ad, input logic [5:0] rg, input logic [7:0] e);
      cond(1, 0);
      xb({ad, 1'b0}, 1'b1, q, a);
      xb({2'h0, rg}, 1'b1, q, a);
      cond(1, 0);
      xb({ad, 1'b1}, 1'b1, q, a);
      cmp("read ack", 0, a);
      xb(8'hff, 1'b1, q, a);
      cmp("read data", e, q);
      cond(0, 1);
   endtask : rdr
   task automatic rs();
      rst <= 1'b1;
      cyc(20);
      rst <= 1'b0;
      cyc(5);
   endtask : rs
   // ------------------------------------------------
   // sequence
   // ------------------------------------------------
   initial
   begin
      cyc(20);
      rst <= 1'b0;
      cyc(5);
      cmp("done after reset", 1, done_n);
      for (int i = 0; i < 12; i++)
      begin
         sel <= (i < 4) ? 2'h3 : 2'(rnd() % 3);
         dem <= (i < 4) ? 2'(i) : 2'(rnd());
         cyc(5);
         cmp("swing a", SWING_700, sw_a);
         cmp("kr pass", sel == 2'h3, kr);
         cmp("swing b", (sel == 2'h3) ? KR_TAB[dem][5:3] : SW_TAB[sel], sw_b);
         cmp("deemph", (sel == 2'h3) ? KR_TAB[dem][2:0] : DE_TAB[dem], de);
      end
      mode <= 2'h3;
      sel <= 2'h0;
      strap <= 4'(rnd()) | 4'h1;
      rs();
      cond(1, 0);
      xb({SLV_BASE + 7'(strap ^ 4'h1), 1'b0}, 1'b1, q, a);
      cmp("foreign addr ack", 1, a);
      cond(0, 1);
      wr(SLV_BASE + 7'(strap), REG_SWA, 8'h1c);
      rdr(SLV_BASE + 7'(strap), REG_SWA, 8'h00);
      wr(SLV_BASE + 7'(strap), REG_CTRL, 8'h08);
      d = 8'(rnd()) | 8'h04;
      wr(SLV_BASE + 7'(strap), REG_SWA, d);
      rdr(SLV_BASE + 7'(strap), REG_SWA, d);
      cmp("swing a reg", d[4:2], sw_a);
      sel <= 2'h3;
      cyc(5);
      rdr(SLV_BASE, REG_SWA, d);
      mode <= 2'h0;
      cyc(5);
      cmp("swing a pin", SWING_700, sw_a);
      cond(1, 0);
      xb({SLV_BASE, 1'b0}, 1'b1, q, a);
      cmp("pin mode ack", 1, a);
      cond(0, 1);
      mode <= 2'h2;
      sel <= 2'h0;
      strap <= 4'(rnd() % 4);
      for (int i = 0; i < 1024; i++) ee.mem[i] = 8'(rnd());
      ee.mem[0] = 8'h80;
      ee.mem[1] = 8'h00;
      ee.mem[2] = 8'h08;
      rs();
      s = 3 + int'(strap) * 38;
      ee.mem[s + 37] = crc_of(s);
      a = 1'b0;
      repeat (2000)
      begin
         @(posedge clk);
         a |= scl_oe | sda_oe | ~done_n;
      end
      cmp("quiet while not requested", 0, a);
      req_n <= 1'b0;
      for (int i = 0; i < 40000 && done_n !== 1'b0; i++) cyc(1);
      cmp("load done", 0, done_n);
      if (done_n !== 1'b0) final_report();
      cyc(20);
      cmp("loaded swing", ee.mem[s + 15][6:4], sw_a);
      cmp("longest burst", 8, 8'(ee.maxb));
      cmp("bus freed", 0, {scl_oe, sda_oe});
      wr(SLV_BASE + 7'(strap), REG_CTRL, 8'h08);
      rdr(SLV_BASE + 7'(strap), REG_CTRL, 8'h08);
      ee.mem[s + 37] = ~ee.mem[s + 37];
      rs();
      cyc(30000);
      cmp("stalled done", 1, done_n);
      cmp("clock held", 1, scl_oe);
      final_report();
   end
endmodule : cfl_config_loader_test
